/* File: inc/xcore_pkg.sv */
package xcore_pkg;

  localparam int DATA_W  = 8;
  localparam int ADDR_W  = 12;
  localparam int PM_W    = 16;
  localparam int PMA_W   = 13;

  localparam logic [7:0] ACC_RST   = 8'h00;
  localparam logic [7:0] PTR_RST   = 8'h00;
  localparam logic [7:0] THB_RST   = 8'h00;

  // Instruction cycle counts
  localparam logic [1:0] CYC_BASE  = 2'h2;
  localparam logic [1:0] CYC_LONG  = 2'h3;
  localparam logic [1:0] CYC_SHORT = 2'h1;

  // Operation codes presented on the operation port
  typedef enum logic [4:0] {
    OP_NOP           = 5'h00,
    OP_SKIP_ZERO     = 5'h01,
    OP_SKIP_ZERO_ACC = 5'h02,
    OP_SKIP_NONZERO  = 5'h03,
    OP_SKIP_BIT_ZERO = 5'h04,
    OP_SKIP_BIT_SET  = 5'h05,
    OP_INC_SKIP      = 5'h06,
    OP_DEC_SKIP      = 5'h07,
    OP_INC_SKIP_ACC  = 5'h08,
    OP_DEC_SKIP_ACC  = 5'h09,
    OP_TAB_PAGE      = 5'h0A,
    OP_TAB_LAST      = 5'h0B,
    OP_TAB_PAGE_INC  = 5'h0C,
    OP_TAB_LAST_INC  = 5'h0D,
    OP_SWAP          = 5'h0E,
    OP_SWAP_ACC      = 5'h0F,
    OP_ADC_ACC       = 5'h10,
    OP_ADC_MEM       = 5'h11,
    OP_ADD_ACC       = 5'h12,
    OP_ADD_MEM       = 5'h13,
    OP_ADD_IMM       = 5'h14,
    OP_AND_MEM       = 5'h15,
    OP_AND_IMM       = 5'h16,
    OP_CLR_MEM       = 5'h17,
    OP_SET_MEM       = 5'h18
  } op_t;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_EXEC  = 4'b0010,
    ST_TABLE = 4'b0100,
    ST_DONE  = 4'b1000
  } state_t;

endpackage : xcore_pkg

/* File: src/xcore_adder.sv */
`timescale 1ns/1ps
module xcore_adder (
  input  wire logic [7:0] a,
  input  wire logic [7:0] b,
  input  wire logic       cin,
  output logic      [7:0] sum,
  output logic            carry,
  output logic            nib_carry,
  output logic            ovf,
  output logic            zero,
  output logic            signed_lt
);
  logic [4:0] low;
  logic [3:0] high;
  logic [8:0] full;
  logic       c6;

  assign low       = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
  assign full      = {1'b0, a} + {1'b0, b} + {8'h00, cin};
  assign high      = {1'b0, a[6:4]} + {1'b0, b[6:4]} + {3'h0, low[4]};
  assign c6        = high[3];
  assign sum       = full[7:0];
  assign carry     = full[8];
  assign nib_carry = low[4];
  assign ovf       = c6 ^ full[8];
  assign zero      = (full[7:0] == 8'h00);
  // Sign of the true result, valid even across a signed wrap
  assign signed_lt = full[7] ^ ovf;
endmodule : xcore_adder

/* File: src/xcore_exec.sv */
`timescale 1ns/1ps
// Summary of operation
// [RL1] An extended skip takes three cycles when it skips and two when it does not.
// [RL2] An extended instruction that changes the program counter low byte takes three cycles.
// [RL3] Byte zero and nonzero tests skip on a zero or nonzero memory byte and leave flags alone.
// [RL4] The zero test with move copies the byte to the accumulator and skips when it is zero.
// [RL5] Bit tests skip when the selected bit is zero, or set for the complementary form.
// [RL6] Increment and decrement skips write the new byte back and skip on zero, flags untouched.
// [RL7] Accumulator forms of increment and decrement skips put the value in the accumulator and skip on zero.
// [RL8] A page table read fetches the word at the pointer, high part to the latch, low byte to memory, in 3 cycles.
// [RL9] A last page table read fetches from the last page at the pointer offset and splits the word the same way.
// [RL10] Pre-increment table reads bump the pointer first and fetch with the new value.
// [RL11] The nibble swap exchanges the halves in place, or writes them to the accumulator in 2 cycles, no flags.
// [RL12] Add with carry sums accumulator, byte and carry into accumulator or byte and updates five flags.
// [RL13] Plain add sums accumulator and byte without carry into either target and updates five flags.
// [RL14] Add immediate sums the accumulator and the operand into the accumulator and updates five flags.
// [RL15] Logical AND of accumulator with byte or operand goes to the accumulator and changes only zero.
// [RL16] Every operation addresses the full data memory directly by its long address.
// [RL17] A taken skip spends its extra cycle as a no-operation that discards the fetched instruction.
module xcore_exec #(
  parameter int ADDR_W = xcore_pkg::ADDR_W,
  parameter int PMA_W  = xcore_pkg::PMA_W,
  parameter int PM_W   = xcore_pkg::PM_W
) (
  input  wire logic              CLK,
  input  wire logic              RST,
  input  wire logic              OP_VALID,
  output logic                   OP_READY,
  input  wire logic [4:0]        OP_CODE,
  input  wire logic [ADDR_W-1:0] OP_ADDR,
  input  wire logic [2:0]        OP_BIT,
  input  wire logic [7:0]        OP_IMM,
  input  wire logic [7:0]        TABLE_PAGE,
  output logic                   DM_RE,
  output logic [ADDR_W-1:0]      DM_ADDR,
  input  wire logic [7:0]        DM_RDATA,
  output logic                   DM_WE,
  output logic [7:0]             DM_WDATA,
  output logic                   PM_RE,
  output logic [PMA_W-1:0]       PM_ADDR,
  input  wire logic [PM_W-1:0]   PM_RDATA,
  output logic [7:0]             ACC,
  output logic [7:0]             TABLE_POINTER,
  output logic [7:0]             TABLE_HIGH_BYTE_LATCH,
  output logic                   CARRY_FLAG,
  output logic                   ZERO_FLAG,
  output logic                   NIBBLE_CARRY_FLAG,
  output logic                   SIGNED_WRAP_FLAG,
  output logic                   SIGNED_RESULT_FLAG,
  output logic                   SKIP_NEXT,
  output logic                   DONE,
  output logic [1:0]             CYCLES_USED
);
  xcore_pkg::state_t state_reg, state_next;

  logic [4:0]        op_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [2:0]        bit_reg;
  logic [7:0]        imm_reg;
  logic [7:0]        acc_reg;
  logic [7:0]        ptr_reg;
  logic [7:0]        thb_reg;
  logic [7:0]        page_reg;
  logic              c_reg, z_reg, ac_reg, ov_reg, sc_reg;
  logic              skip_reg;
  logic              done_reg;
  logic [1:0]        cyc_reg;
  logic [1:0]        cnt_reg;
  logic              we_reg;
  logic [7:0]        wdata_reg;
  logic              pm_re_reg;
  logic [PMA_W-1:0]  pm_addr_reg;

  // Operation class decodes
  wire is_tab      = (op_reg >= 5'(xcore_pkg::OP_TAB_PAGE)) && (op_reg <= 5'(xcore_pkg::OP_TAB_LAST_INC));
  wire is_tab_inc  = (op_reg == 5'(xcore_pkg::OP_TAB_PAGE_INC)) || (op_reg == 5'(xcore_pkg::OP_TAB_LAST_INC));
  wire is_tab_last = (op_reg == 5'(xcore_pkg::OP_TAB_LAST)) || (op_reg == 5'(xcore_pkg::OP_TAB_LAST_INC));
  wire is_base     = (op_reg >= 5'(xcore_pkg::OP_ADC_ACC)) && (op_reg <= 5'(xcore_pkg::OP_AND_IMM));
  wire use_carry   = (op_reg == 5'(xcore_pkg::OP_ADC_ACC)) || (op_reg == 5'(xcore_pkg::OP_ADC_MEM));

  // Datapath
  wire [7:0] mem_inc  = DM_RDATA + 8'h01;
  wire [7:0] mem_dec  = DM_RDATA - 8'hFF + 8'hFE;
  wire [7:0] mem_swap = {DM_RDATA[3:0], DM_RDATA[7:4]};
  wire       sel_bit  = DM_RDATA[bit_reg];
  wire [7:0] add_b    = (op_reg == 5'(xcore_pkg::OP_ADD_IMM)) ? imm_reg : DM_RDATA;
  wire [7:0] and_b    = (op_reg == 5'(xcore_pkg::OP_AND_IMM)) ? imm_reg : DM_RDATA;
  wire [7:0] and_res  = acc_reg & and_b;

  logic [7:0] add_sum;
  logic       add_c, add_ac, add_ov, add_z, add_sc;

  xcore_adder u_adder (
    .a         (acc_reg),
    .b         (add_b),
    .cin       (use_carry & c_reg),
    .sum       (add_sum),
    .carry     (add_c),
    .nib_carry (add_ac),
    .ovf       (add_ov),
    .zero      (add_z),
    .signed_lt (add_sc)
  );

  // Skip decision taken in the execute cycle
  logic skip_now;
  always_comb begin
    case (op_reg)
      5'(xcore_pkg::OP_SKIP_ZERO):     skip_now = (DM_RDATA == 8'h00); // RL3
      5'(xcore_pkg::OP_SKIP_ZERO_ACC): skip_now = (DM_RDATA == 8'h00); // RL4
      5'(xcore_pkg::OP_SKIP_NONZERO):  skip_now = (DM_RDATA != 8'h00); // RL3
      5'(xcore_pkg::OP_SKIP_BIT_ZERO): skip_now = ~sel_bit; // RL5
      5'(xcore_pkg::OP_SKIP_BIT_SET):  skip_now = sel_bit; // RL5
      5'(xcore_pkg::OP_INC_SKIP),
      5'(xcore_pkg::OP_INC_SKIP_ACC):  skip_now = (mem_inc == 8'h00); // RL6 RL7
      5'(xcore_pkg::OP_DEC_SKIP),
      5'(xcore_pkg::OP_DEC_SKIP_ACC):  skip_now = (mem_dec == 8'h00); // RL6 RL7
      default:                         skip_now = 1'b0;
    endcase
  end

  // Memory write-back decision
  logic       mem_we;
  logic [7:0] mem_wd;
  always_comb begin
    mem_we = 1'b0;
    mem_wd = 8'h00;
    case (op_reg)
      5'(xcore_pkg::OP_INC_SKIP): begin mem_we = 1'b1; mem_wd = mem_inc; end // RL6
      5'(xcore_pkg::OP_DEC_SKIP): begin mem_we = 1'b1; mem_wd = mem_dec; end // RL6
      5'(xcore_pkg::OP_SWAP):     begin mem_we = 1'b1; mem_wd = mem_swap; end // RL11
      5'(xcore_pkg::OP_ADC_MEM),
      5'(xcore_pkg::OP_ADD_MEM):  begin mem_we = 1'b1; mem_wd = add_sum; end // RL12 RL13
      5'(xcore_pkg::OP_CLR_MEM):  begin mem_we = 1'b1; mem_wd = 8'h00; end
      5'(xcore_pkg::OP_SET_MEM):  begin mem_we = 1'b1; mem_wd = 8'hFF; end
      default: ;
    endcase
  end

  // Accumulator update decision
  logic       acc_we;
  logic [7:0] acc_wd;
  always_comb begin
    acc_we = 1'b1;
    acc_wd = acc_reg;
    case (op_reg)
      5'(xcore_pkg::OP_SKIP_ZERO_ACC): acc_wd = DM_RDATA; // RL4
      5'(xcore_pkg::OP_INC_SKIP_ACC):  acc_wd = mem_inc; // RL7
      5'(xcore_pkg::OP_DEC_SKIP_ACC):  acc_wd = mem_dec; // RL7
      5'(xcore_pkg::OP_SWAP_ACC):      acc_wd = mem_swap; // RL11
      5'(xcore_pkg::OP_ADC_ACC),
      5'(xcore_pkg::OP_ADD_ACC),
      5'(xcore_pkg::OP_ADD_IMM):       acc_wd = add_sum; // RL12 RL13 RL14
      5'(xcore_pkg::OP_AND_MEM),
      5'(xcore_pkg::OP_AND_IMM):       acc_wd = and_res; // RL15
      default:                         acc_we = 1'b0;
    endcase
  end

  wire flags5 = is_base && (op_reg != 5'(xcore_pkg::OP_AND_MEM)) && (op_reg != 5'(xcore_pkg::OP_AND_IMM));
  wire flag_z_and = (op_reg == 5'(xcore_pkg::OP_AND_MEM)) || (op_reg == 5'(xcore_pkg::OP_AND_IMM));

  // Pointer used by the table fetch, incremented first where asked
  wire [7:0]       ptr_use  = is_tab_inc ? ptr_reg + 8'h01 : ptr_reg; // RL10
  wire [7:0]       page_use = is_tab_last ? 8'hFF : page_reg; // RL9
  wire [15:0]      pm_full  = {page_use, ptr_use};
  wire             last_cyc = (state_reg == xcore_pkg::ST_EXEC) && (cnt_reg == 2'h1);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      xcore_pkg::ST_IDLE:  if (OP_VALID) state_next = xcore_pkg::ST_EXEC;
      xcore_pkg::ST_EXEC:  state_next = is_tab ? xcore_pkg::ST_TABLE : (skip_now ? xcore_pkg::ST_DONE : xcore_pkg::ST_IDLE); // RL1 RL17
      xcore_pkg::ST_TABLE: state_next = xcore_pkg::ST_IDLE; // RL8
      xcore_pkg::ST_DONE:  state_next = xcore_pkg::ST_IDLE; // RL17
      default:             state_next = xcore_pkg::ST_IDLE;
    endcase
  end

  wire in_exec  = (state_reg == xcore_pkg::ST_EXEC);
  wire in_table = (state_reg == xcore_pkg::ST_TABLE);
  wire in_done  = (state_reg == xcore_pkg::ST_DONE);
  wire take     = (state_reg == xcore_pkg::ST_IDLE) && OP_VALID;
  wire finish   = (in_exec && !is_tab && !skip_now) || in_table || in_done;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_reg <= xcore_pkg::ST_IDLE;
      op_reg    <= 5'h00;
      addr_reg  <= '0;
      bit_reg   <= 3'h0;
      imm_reg   <= 8'h00;
      page_reg  <= 8'h00;
      cnt_reg   <= 2'h0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= take ? 2'h1 : cnt_reg;
      if (take) begin
        op_reg   <= OP_CODE;
        addr_reg <= OP_ADDR; // RL16
        bit_reg  <= OP_BIT;
        imm_reg  <= OP_IMM;
        page_reg <= TABLE_PAGE;
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      acc_reg <= xcore_pkg::ACC_RST;
      c_reg   <= 1'b0;
      z_reg   <= 1'b0;
      ac_reg  <= 1'b0;
      ov_reg  <= 1'b0;
      sc_reg  <= 1'b0;
    end else if (in_exec) begin
      if (acc_we) acc_reg <= acc_wd;
      if (flags5) begin
        c_reg  <= add_c;
        z_reg  <= add_z;
        ac_reg <= add_ac;
        ov_reg <= add_ov;
        sc_reg <= add_sc; // RL12 RL13 RL14
      end else if (flag_z_and) begin
        z_reg <= (and_res == 8'h00); // RL15
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ptr_reg     <= xcore_pkg::PTR_RST;
      thb_reg     <= xcore_pkg::THB_RST;
      we_reg      <= 1'b0;
      wdata_reg   <= 8'h00;
      pm_re_reg   <= 1'b0;
      pm_addr_reg <= '0;
    end else begin
      we_reg    <= 1'b0;
      pm_re_reg <= 1'b0;
      if (in_exec && is_tab) begin
        ptr_reg     <= ptr_use; // RL10
        pm_re_reg   <= 1'b1;
        pm_addr_reg <= pm_full[PMA_W-1:0]; // RL8 RL9
      end else if (in_exec) begin
        we_reg    <= mem_we;
        wdata_reg <= mem_wd;
      end
      if (in_table) begin
        thb_reg   <= PM_RDATA[PM_W-1:8]; // RL8
        we_reg    <= 1'b1;
        wdata_reg <= PM_RDATA[7:0]; // RL8
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      skip_reg <= 1'b0;
      done_reg <= 1'b0;
      cyc_reg  <= 2'h0;
    end else begin
      done_reg <= finish;
      if (in_exec) skip_reg <= skip_now;
      if (take) skip_reg <= 1'b0;
      if (finish) cyc_reg <= in_exec ? xcore_pkg::CYC_BASE : xcore_pkg::CYC_LONG; // RL1 RL2 RL11
    end
  end

  assign OP_READY              = (state_reg == xcore_pkg::ST_IDLE);
  assign DM_RE                 = in_exec;
  assign DM_ADDR               = addr_reg;
  assign DM_WE                 = we_reg;
  assign DM_WDATA              = wdata_reg;
  assign PM_RE                 = pm_re_reg;
  assign PM_ADDR               = pm_addr_reg;
  assign ACC                   = acc_reg;
  assign TABLE_POINTER         = ptr_reg;
  assign TABLE_HIGH_BYTE_LATCH = thb_reg;
  assign CARRY_FLAG            = c_reg;
  assign ZERO_FLAG             = z_reg;
  assign NIBBLE_CARRY_FLAG     = ac_reg;
  assign SIGNED_WRAP_FLAG      = ov_reg;
  assign SIGNED_RESULT_FLAG    = sc_reg;
  assign SKIP_NEXT             = skip_reg;
  assign DONE                  = done_reg;
  assign CYCLES_USED           = cyc_reg;
endmodule : xcore_exec

/* File: bench/xcore_mem_model.sv */
`timescale 1ns/1ps
module xcore_mem_model (
  input  wire logic        CLK,
  input  wire logic        DM_RE,
  input  wire logic [11:0] DM_ADDR,
  output logic      [7:0]  DM_RDATA,
  input  wire logic        DM_WE,
  input  wire logic [7:0]  DM_WDATA,
  input  wire logic        PM_RE,
  input  wire logic [12:0] PM_ADDR,
  output logic      [15:0] PM_RDATA
);
  logic [7:0]  mem [0:4095];
  logic [7:0]  dm_last_reg = 8'h00;
  logic [15:0] pm_last_reg = 16'h0000;
  // Table words are a fixed function of the word address
  wire  [15:0] pm_word = {PM_ADDR[7:0] ^ 8'hA5, PM_ADDR[12:5]};
  // Unread lines show the inverse of the last value
  assign DM_RDATA = DM_RE ? mem[DM_ADDR] : ~dm_last_reg;
  assign PM_RDATA = PM_RE ? pm_word : ~pm_last_reg;
  always @(posedge CLK) begin
    if (DM_RE) dm_last_reg <= DM_RDATA;
    if (PM_RE) pm_last_reg <= PM_RDATA;
    if (DM_WE) mem[DM_ADDR] <= DM_WDATA;
  end
endmodule : xcore_mem_model

/* File: bench/xcore_exec_sva.sv */
`timescale 1ns/1ps
module xcore_exec_sva #(
  parameter int ADDR_W = xcore_pkg::ADDR_W,
  parameter int PM_W   = xcore_pkg::PM_W
) (
  input wire logic              CLK,
  input wire logic              RST,
  input wire logic              OP_VALID,
  input wire logic              OP_READY,
  input wire logic [4:0]        OP_CODE,
  input wire logic [ADDR_W-1:0] OP_ADDR,
  input wire logic              DM_RE,
  input wire logic [ADDR_W-1:0] DM_ADDR,
  input wire logic [7:0]        DM_RDATA,
  input wire logic              DM_WE,
  input wire logic [7:0]        DM_WDATA,
  input wire logic              PM_RE,
  input wire logic [PM_W-1:0]   PM_RDATA,
  input wire logic [7:0]        ACC,
  input wire logic [7:0]        TABLE_HIGH_BYTE_LATCH,
  input wire logic              CARRY_FLAG,
  input wire logic              ZERO_FLAG,
  input wire logic              NIBBLE_CARRY_FLAG,
  input wire logic              SIGNED_WRAP_FLAG,
  input wire logic              SIGNED_RESULT_FLAG,
  input wire logic              SKIP_NEXT,
  input wire logic              DONE,
  input wire logic [1:0]        CYCLES_USED
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  wire       take    = OP_VALID && OP_READY;
  wire [7:0] swapped = {DM_RDATA[3:0], DM_RDATA[7:4]};
  wire [4:0] flags   = {SIGNED_RESULT_FLAG, SIGNED_WRAP_FLAG, NIBBLE_CARRY_FLAG, CARRY_FLAG, ZERO_FLAG};
  AST_DONE_CYC: assert property (DONE |-> CYCLES_USED inside {2'h2, 2'h3})
    else $error("cycle count out of range");
  AST_SKIP_THREE: assert property (DONE && SKIP_NEXT |-> CYCLES_USED == 2'h3)
    else $error("taken skip not three cycles");
  AST_NOSKIP_TWO: assert property (take |=> ##1 (DONE || SKIP_NEXT || PM_RE))
    else $error("plain op not done in two cycles");
  AST_SKIP_NOP: assert property (take ##2 SKIP_NEXT |-> !DONE && !PM_RE && !DM_RE ##1 DONE)
    else $error("skip cycle not idle");
  AST_SKIPZ: assert property (take && OP_CODE == xcore_pkg::OP_SKIP_ZERO |=> ##1 SKIP_NEXT == ($past(DM_RDATA) == 8'h00))
    else $error("zero test wrong");
  AST_ADDR: assert property (take |=> DM_RE && DM_ADDR == $past(OP_ADDR) && !OP_READY)
    else $error("operand address not used");
  AST_TAB_LATCH: assert property (PM_RE |=> TABLE_HIGH_BYTE_LATCH == $past(PM_RDATA[15:8]) && DONE)
    else $error("table latch wrong");
  AST_TAB_WRITE: assert property (PM_RE |=> DM_WE && DM_WDATA == $past(PM_RDATA[7:0]) && CYCLES_USED == 2'h3)
    else $error("table low byte wrong");
  AST_FLAGS_KEEP: assert property (DONE && CYCLES_USED == 2'h3 |-> flags == $past(flags, 3))
    else $error("flags changed");
  AST_SWAP: assert property (take && OP_CODE == xcore_pkg::OP_SWAP_ACC |=> ##1 DONE && ACC == $past(swapped))
    else $error("swap to acc wrong");
  COV_TAB: cover property (PM_RE);
  COV_SKIP: cover property (DONE && SKIP_NEXT);
  COV_ADC: cover property (take && OP_CODE == xcore_pkg::OP_ADC_MEM);
endmodule : xcore_exec_sva
bind xcore_exec xcore_exec_sva #(.ADDR_W(ADDR_W), .PM_W(PM_W)) u_sva (.*);

/* File: bench/extended_skip_table_and_add_logic_test.sv */
`timescale 1ns/1ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin fail_count++; \
  $display("ERROR %0t got %0h exp %0h", $time, got, exp); end end
module extended_skip_table_and_add_logic_test;
  logic        CLK = 1'b0, RST = 1'b1, OP_VALID = 1'b0;
  logic [4:0]  OP_CODE = 5'h00;
  logic [11:0] OP_ADDR = 12'h000;
  logic [2:0]  OP_BIT = 3'h0;
  logic [7:0]  OP_IMM = 8'h00, TABLE_PAGE = 8'h05;
  logic        OP_READY, DM_RE, DM_WE, PM_RE, SKIP_NEXT, DONE;
  logic        CARRY_FLAG, ZERO_FLAG, NIBBLE_CARRY_FLAG, SIGNED_WRAP_FLAG, SIGNED_RESULT_FLAG;
  logic [11:0] DM_ADDR;
  logic [12:0] PM_ADDR;
  logic [15:0] PM_RDATA;
  logic [7:0]  DM_RDATA, DM_WDATA, ACC, TABLE_POINTER, TABLE_HIGH_BYTE_LATCH;
  logic [1:0]  CYCLES_USED;
  wire  [4:0]  flags = {SIGNED_RESULT_FLAG, SIGNED_WRAP_FLAG, NIBBLE_CARRY_FLAG, CARRY_FLAG, ZERO_FLAG};
  int          fail_count = 0, tests_run = 0;
  xcore_pkg::op_t ops [6] = '{xcore_pkg::OP_ADD_IMM, xcore_pkg::OP_ADD_ACC, xcore_pkg::OP_ADC_ACC,
                              xcore_pkg::OP_ADC_MEM, xcore_pkg::OP_ADD_MEM, xcore_pkg::OP_ADC_MEM};
  logic [7:0]  mv  [6] = '{8'h00, 8'h71, 8'h7F, 8'h80, 8'h0F, 8'hFF};
  xcore_exec dut (.*);
  xcore_mem_model mdl (.*);
  initial forever #20 CLK = ~CLK;
  task automatic wrap_up;
    $display("Counts: %0d compared, %0d mismatched", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up
  // Result {sc, ov, ac, c, z, sum}
  function automatic logic [12:0] add_exp(input logic [7:0] a, input logic [7:0] b, input logic c);
    logic [8:0] s;
    logic       ov;
    s  = {1'b0, a} + {1'b0, b} + {8'h00, c};
    ov = (a[7] == b[7]) && (s[7] != a[7]);
    return {ov ^ s[7], ov, ({1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, c}) > 5'h0F, s[8], s[7:0] == 8'h00, s[7:0]};
  endfunction : add_exp
  // Idle core has OP_READY high, so the offer is taken at the next edge
  task automatic run_op(input xcore_pkg::op_t op, input logic [11:0] a, input logic [2:0] b, input logic [7:0] imm,
                        input logic [1:0] cyc, input logic skip);
    @(posedge CLK);
    OP_VALID <= 1'b1;
    OP_CODE  <= op;
    OP_ADDR  <= a;
    OP_BIT   <= b;
    OP_IMM   <= imm;
    @(posedge CLK);
    OP_VALID <= 1'b0;
    #1;
    for (int n = 0; n < 8 && DONE !== 1'b1; n++) begin
      @(posedge CLK);
      #1;
    end
    `CHK(DONE, 1'b1)
    `CHK(CYCLES_USED, cyc)
    `CHK(SKIP_NEXT, skip)
    @(posedge CLK);
    #1;
  endtask : run_op
  task automatic skip_case(input xcore_pkg::op_t op, input logic [7:0] v, input logic [2:0] b, input logic skip,
                           input logic [7:0] mem_e);
    logic [4:0] f;
    f = flags;
    mdl.mem[12'hA40] = v;
    run_op(op, 12'hA40, b, 8'h00, skip ? 2'h3 : 2'h2, skip);
    `CHK(mdl.mem[12'hA40], mem_e)
    `CHK(flags, f)
  endtask : skip_case
  task automatic tab_case(input xcore_pkg::op_t op, input logic [7:0] ptr, input logic [7:0] page);
    logic [12:0] pa;
    pa = 13'({page, ptr});
    run_op(op, 12'hB00, 3'h0, 8'h00, 2'h3, 1'b0);
    `CHK(TABLE_POINTER, ptr)
    `CHK(TABLE_HIGH_BYTE_LATCH, pa[7:0] ^ 8'hA5)
    `CHK(mdl.mem[12'hB00], pa[12:5])
  endtask : tab_case
  initial begin
    #(40 * 3000);
    fail_count++;
    wrap_up();
  end
  initial begin
    logic [12:0] r;
    logic [7:0]  acc_e;
    logic        cy_e, m;
    logic [11:0] a;
    repeat (8) @(posedge CLK);
    RST <= 1'b0;
    #1;
    `CHK({ACC, TABLE_POINTER, TABLE_HIGH_BYTE_LATCH}, {xcore_pkg::ACC_RST, xcore_pkg::PTR_RST, xcore_pkg::THB_RST})
    `CHK(OP_READY, 1'b1)
    $display("test reset done");
    acc_e = xcore_pkg::ACC_RST;
    cy_e  = 1'b0;
    for (int i = 0; i < 6; i++) begin
      a = 12'h5C0 + 12'(i);
      m = ops[i] inside {xcore_pkg::OP_ADC_MEM, xcore_pkg::OP_ADD_MEM};
      mdl.mem[a] = mv[i];
      run_op(ops[i], a, 3'h0, 8'h8F, 2'h2, 1'b0);
      r = add_exp(acc_e, (ops[i] == xcore_pkg::OP_ADD_IMM) ? 8'h8F : mv[i],
                  (ops[i] inside {xcore_pkg::OP_ADC_ACC, xcore_pkg::OP_ADC_MEM}) & cy_e);
      `CHK(flags, r[12:8])
      `CHK(ACC, m ? acc_e : r[7:0])
      `CHK(mdl.mem[a], m ? r[7:0] : mv[i])
      acc_e = m ? acc_e : r[7:0];
      cy_e  = r[9];
    end
    mdl.mem[12'h5D0] = 8'h0F;
    r[4:0] = flags;
    run_op(xcore_pkg::OP_AND_MEM, 12'h5D0, 3'h0, 8'h00, 2'h2, 1'b0);
    `CHK({ACC, flags}, {acc_e & 8'h0F, r[4:1], acc_e[3:0] == 4'h0})
    $display("test arithmetic done");
    skip_case(xcore_pkg::OP_SKIP_ZERO_ACC, 8'hF3, 3'h0, 1'b0, 8'hF3);
    `CHK(ACC, 8'hF3)
    run_op(xcore_pkg::OP_AND_IMM, 12'h000, 3'h0, 8'h3C, 2'h2, 1'b0);
    `CHK({ACC, ZERO_FLAG}, {8'h30, 1'b0})
    skip_case(xcore_pkg::OP_SKIP_ZERO, 8'h00, 3'h0, 1'b1, 8'h00);
    skip_case(xcore_pkg::OP_SKIP_ZERO, 8'h01, 3'h0, 1'b0, 8'h01);
    skip_case(xcore_pkg::OP_SKIP_NONZERO, 8'h80, 3'h0, 1'b1, 8'h80);
    skip_case(xcore_pkg::OP_SKIP_NONZERO, 8'h00, 3'h0, 1'b0, 8'h00);
    skip_case(xcore_pkg::OP_SKIP_BIT_ZERO, 8'hEF, 3'h4, 1'b1, 8'hEF);
    skip_case(xcore_pkg::OP_SKIP_BIT_ZERO, 8'h10, 3'h4, 1'b0, 8'h10);
    skip_case(xcore_pkg::OP_SKIP_BIT_SET, 8'h10, 3'h4, 1'b1, 8'h10);
    skip_case(xcore_pkg::OP_SKIP_BIT_SET, 8'hEF, 3'h4, 1'b0, 8'hEF);
    skip_case(xcore_pkg::OP_INC_SKIP, 8'hFF, 3'h0, 1'b1, 8'h00);
    skip_case(xcore_pkg::OP_INC_SKIP, 8'h7F, 3'h0, 1'b0, 8'h80);
    skip_case(xcore_pkg::OP_DEC_SKIP, 8'h01, 3'h0, 1'b1, 8'h00);
    skip_case(xcore_pkg::OP_DEC_SKIP, 8'h00, 3'h0, 1'b0, 8'hFF);
    skip_case(xcore_pkg::OP_INC_SKIP_ACC, 8'hFF, 3'h0, 1'b1, 8'hFF);
    `CHK(ACC, 8'h00)
    skip_case(xcore_pkg::OP_DEC_SKIP_ACC, 8'h43, 3'h0, 1'b0, 8'h43);
    `CHK(ACC, 8'h42)
    skip_case(xcore_pkg::OP_SKIP_ZERO_ACC, 8'h00, 3'h0, 1'b1, 8'h00);
    `CHK(ACC, 8'h00)
    skip_case(xcore_pkg::OP_SWAP, 8'h3C, 3'h0, 1'b0, 8'hC3);
    skip_case(xcore_pkg::OP_SWAP_ACC, 8'h3C, 3'h0, 1'b0, 8'h3C);
    `CHK(ACC, 8'hC3)
    skip_case(xcore_pkg::OP_CLR_MEM, 8'h5A, 3'h0, 1'b0, 8'h00);
    skip_case(xcore_pkg::OP_SET_MEM, 8'h5A, 3'h0, 1'b0, 8'hFF);
    $display("test skips done");
    tab_case(xcore_pkg::OP_TAB_PAGE, 8'h00, 8'h05);
    tab_case(xcore_pkg::OP_TAB_PAGE_INC, 8'h01, 8'h05);
    @(posedge CLK);
    TABLE_PAGE <= 8'h0A;
    tab_case(xcore_pkg::OP_TAB_LAST, 8'h01, 8'hFF);
    tab_case(xcore_pkg::OP_TAB_LAST_INC, 8'h02, 8'hFF);
    $display("test table done");
    wrap_up();
  end
endmodule : extended_skip_table_and_add_logic_test
